// *** common/csr_pkg.sv ***
package csr_pkg;
  // ****************************************************************
  // register indexes within the system module
  // ****************************************************************
  localparam logic [3:0] IDX_ACC_SEL = 4'h0;
  localparam logic [3:0] IDX_PTR_CTL = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h4;
  localparam logic [3:0] IDX_IRQ_CTL = 4'h5;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h6;
  localparam int ACC_W = 16;
  localparam int NUM_MOD = 6;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_ACC_SEL = 8'h00;
  localparam logic [7:0] RST_PTR_CTL = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h80;
  localparam logic [7:0] RST_IRQ_CTL = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PC_ZERO = 7;
  localparam int PC_DIR = 6;
  localparam int SF_Z = 7;
  localparam int SF_S = 6;
  localparam int SF_U1 = 4;
  localparam int SF_U0 = 3;
  localparam int SF_OV = 2;
  localparam int SF_C = 1;
  localparam int SF_E = 0;
  localparam int IC_GIE = 0;
  localparam int IC_INS = 1;
  localparam int IC_CGD = 5;
  localparam int IM_SYS = 7;
  localparam logic [7:0] PTR_CTL_RW = 8'h47;
  localparam logic [7:0] STATUS_RW = 8'h1b;
  localparam logic [7:0] IRQ_CTL_RW = 8'h23;
  localparam logic [7:0] IRQ_MASK_RW = 8'hbf;
  // ****************************************************************
  // alu operation codes
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD = 3'h1,
    OP_ADD_WITH_CARRY_OP = 3'h2,
    OP_SUB = 3'h3,
    OP_SUBTRACT_WITH_BORROW_OP = 3'h4,
    OP_CMP = 3'h5,
    OP_LOGIC = 3'h6
  } csr_op_t;
  typedef enum logic [1:0] {
    IS_IDLE = 2'b00,
    IS_SERVE = 2'b01
  } csr_irq_state_t;
endpackage

// *** common/csr_step_if.sv ***
`timescale 1ns/100ps
interface csr_step_if;
  logic [3:0] cur;
  logic [2:0] modulus;
  logic down;
  logic [3:0] nxt;
  logic active;
  modport ctl (output cur, output modulus, output down, input nxt, input active);
  modport calc (input cur, input modulus, input down, output nxt, output active);
endinterface

// *** verilog/csr_ptr_step.sv ***
`timescale 1ns/100ps
module csr_ptr_step (
  csr_step_if.calc st // stepping request and result
);
  logic [3:0] inc;
  logic [3:0] dec;
  logic [3:0] keep;
  always_comb begin
    inc = st.cur + 4'h1;
    dec = st.cur - 4'h1;
    case (st.modulus)
      3'b001: keep = 4'he;
      3'b010: keep = 4'hc;
      3'b011: keep = 4'h8;
      default: keep = 4'h0;
    endcase
    st.active = (st.modulus != 3'b000);
    // direction ignored when stepping off
    if (!st.active) begin
      st.nxt = st.cur;
    end else if (st.down) begin
      st.nxt = (st.cur & keep) | (dec & ~keep);
    end else begin
      st.nxt = (st.cur & keep) | (inc & ~keep);
    end
  end
endmodule // csr_ptr_step

// *** verilog/csr_flag_calc.sv ***
`timescale 1ns/100ps
module csr_flag_calc
  import csr_pkg::*;
(
  input wire csr_op_t op_i, // alu operation
  input wire logic [ACC_W-1:0] a_i, // accumulator operand
  input wire logic [ACC_W-1:0] b_i, // source operand
  input wire logic cin_i, // carry flag in
  output logic carry_o, // carry or borrow
  output logic ovf_o, // signed overflow
  output logic equal_o, // operands match
  output logic arith_o, // op touches carry/overflow
  output logic [ACC_W-1:0] sum_o // result
);
  logic [ACC_W:0] full;
  logic [ACC_W-1:0] low;
  logic [ACC_W-1:0] bb;
  logic ci;
  logic sub;
  always_comb begin
    sub = (op_i == OP_SUB) || (op_i == OP_SUBTRACT_WITH_BORROW_OP);
    bb = sub ? ~b_i : b_i;
    case (op_i)
      OP_ADD_WITH_CARRY_OP: ci = cin_i;
      OP_SUB: ci = 1'b1;
      OP_SUBTRACT_WITH_BORROW_OP: ci = ~cin_i;
      default: ci = 1'b0;
    endcase
    full = {1'b0, a_i} + {1'b0, bb} + {{ACC_W{1'b0}}, ci};
    low = {1'b0, a_i[ACC_W-2:0]} + {1'b0, bb[ACC_W-2:0]} + {{(ACC_W-1){1'b0}}, ci};
    arith_o = (op_i == OP_ADD) || (op_i == OP_ADD_WITH_CARRY_OP) || sub;
    carry_o = sub ? ~full[ACC_W] : full[ACC_W];
    ovf_o = full[ACC_W] ^ low[ACC_W-1];
    equal_o = (a_i == b_i);
    sum_o = full[ACC_W-1:0];
  end
endmodule // csr_flag_calc

// *** verilog/csr_core_regs.sv ***
`timescale 1ns/100ps
// Summary of operation
// - low four select bits pick accumulator
// - nonzero modulus steps pointer after operations
// - modulus codes 1..4 give modulo 2..16
// - codes 5..7 step modulo sixteen
// - direction ignored when modulus is zero
// - auto step beats moved accumulator value
// - zero strobe clears pointer, self clears
// - pointer, control, irq registers reset zero
// - status resets to 80h
// - compare sets or clears equal flag
// - add/sub ops set or clear carry
// - overflow is carry14 xor carry15
// - sign mirrors accumulator bit 15
// - zero flag set when accumulator zero
// - zero, sign, overflow are read only
// - global enable gates all interrupts
// - acknowledge sets in-service, blocks further
// - return or pop clears in-service
// - gating disable bit turns gating off
// - mask bits gate module/system requests
// - reserved bits read zero
// - system irq needs enable, mask, no service
module csr_core_regs
  import csr_pkg::*;
(
  input wire logic CLK_I, // system clock
  input wire logic NRST_I, // synchronous reset, low
  input wire logic CE_I, // clock enable
  input wire logic WR_I, // register write strobe
  input wire logic [3:0] WIDX_I, // write index
  input wire logic [7:0] WDATA_I, // write data
  input wire logic [3:0] RIDX_I, // read index
  input wire logic MOVE_ACC_I, // write is acc moved to pointer
  input wire csr_op_t OP_I, // alu operation this cycle
  input wire logic [ACC_W-1:0] OPA_I, // active accumulator operand
  input wire logic [ACC_W-1:0] OPB_I, // source operand
  input wire logic [ACC_W-1:0] ACC_I, // active accumulator value
  input wire logic ACC_WR_I, // accumulator written this cycle
  input wire logic [ACC_W-1:0] ACC_NEW_I, // value written to accumulator
  input wire logic IRQ_ACK_I, // interrupt acknowledged
  input wire logic IRQ_RET_I, // return or pop interrupt
  input wire logic [NUM_MOD-1:0] MOD_REQ_I, // module requests
  input wire logic SYS_REQ_I, // system requests
  output logic [7:0] RDATA_O, // read data
  output logic [3:0] ACC_SEL_O, // active accumulator index
  output logic [ACC_W-1:0] ALU_RES_O, // alu result
  output logic IRQ_O, // interrupt may be taken
  output logic [NUM_MOD:0] IRQ_PEND_O, // gated pending requests
  output logic CLK_GATE_EN_O // clock gating active
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [3:0] sel_q, sel_d;
  logic [7:0] pctl_q, pctl_d;
  logic [7:0] sts_q, sts_d;
  logic [7:0] ictl_q, ictl_d;
  logic [7:0] imsk_q, imsk_d;
  logic [7:0] rdata_q, rdata_d;
  logic [ACC_W-1:0] res_q, res_d;
  logic irq_q, irq_d;
  logic [NUM_MOD:0] pend_q, pend_d;
  csr_irq_state_t ist_q, ist_d;
  logic carry, ovf, equal, arith;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] acc_now;
  logic [NUM_MOD:0] gated;
  logic alu_op;
  csr_step_if st();

  assign st.cur = sel_q;
  assign st.modulus = pctl_q[2:0];
  assign st.down = pctl_q[PC_DIR];

  csr_ptr_step u_step (
    .st(st)
  );

  csr_flag_calc u_flags (
    .op_i(OP_I),
    .a_i(OPA_I),
    .b_i(OPB_I),
    .cin_i(sts_q[SF_C]),
    .carry_o(carry),
    .ovf_o(ovf),
    .equal_o(equal),
    .arith_o(arith),
    .sum_o(sum)
  );

  function automatic logic wr_at(input logic [3:0] idx);
    wr_at = WR_I && (WIDX_I == idx);
  endfunction

  // ****************************************************************
  // pointer and control
  // ****************************************************************
  always_comb begin
    alu_op = (OP_I != OP_NONE);
    sel_d = sel_q;
    pctl_d = pctl_q;
    if (wr_at(IDX_PTR_CTL)) begin
      pctl_d = WDATA_I & PTR_CTL_RW;
    end
    if (wr_at(IDX_PTR_CTL) && WDATA_I[PC_ZERO]) begin
      sel_d = 4'h0;
    end else if (alu_op && st.active) begin
      sel_d = st.nxt;
    end else if (wr_at(IDX_ACC_SEL) && !(MOVE_ACC_I && st.active)) begin
      sel_d = WDATA_I[3:0];
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  always_comb begin
    acc_now = ACC_WR_I ? ACC_NEW_I : ACC_I;
    res_d = alu_op ? sum : res_q;
    sts_d = sts_q;
    if (wr_at(IDX_STATUS)) begin
      sts_d = (sts_q & ~STATUS_RW) | (WDATA_I & STATUS_RW);
    end
    if (OP_I == OP_CMP) begin
      sts_d[SF_E] = equal;
    end
    if (arith) begin
      sts_d[SF_C] = carry;
      sts_d[SF_OV] = ovf;
    end
    sts_d[SF_S] = acc_now[ACC_W-1];
    sts_d[SF_Z] = (acc_now == '0);
    sts_d[5] = 1'b0;
  end

  // ****************************************************************
  // interrupt control
  // ****************************************************************
  always_comb begin
    ictl_d = ictl_q;
    imsk_d = imsk_q;
    ist_d = ist_q;
    if (wr_at(IDX_IRQ_CTL)) begin
      ictl_d = WDATA_I & IRQ_CTL_RW;
    end
    if (wr_at(IDX_IRQ_MASK)) begin
      imsk_d = WDATA_I & IRQ_MASK_RW;
    end
    // hardware set wins over a software clear in the same cycle
    if (IRQ_ACK_I) begin
      ictl_d[IC_INS] = 1'b1;
    end else if (IRQ_RET_I) begin
      ictl_d[IC_INS] = 1'b0;
    end
    case (ist_q)
      IS_IDLE: if (ictl_d[IC_INS]) ist_d = IS_SERVE;
      IS_SERVE: if (!ictl_d[IC_INS]) ist_d = IS_IDLE;
      default: ist_d = IS_IDLE;
    endcase
    gated = {SYS_REQ_I & imsk_d[IM_SYS], MOD_REQ_I & imsk_d[NUM_MOD-1:0]};
    pend_d = gated;
    irq_d = ictl_d[IC_GIE] && !ictl_d[IC_INS] && (gated != '0);
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    if (RIDX_I == IDX_ACC_SEL) begin
      rdata_d = {4'h0, sel_d};
    end else if (RIDX_I == IDX_PTR_CTL) begin
      rdata_d = pctl_d;
    end else if (RIDX_I == IDX_STATUS) begin
      rdata_d = sts_d;
    end else if (RIDX_I == IDX_IRQ_CTL) begin
      rdata_d = ictl_d;
    end else if (RIDX_I == IDX_IRQ_MASK) begin
      rdata_d = imsk_d;
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sel_q <= RST_ACC_SEL[3:0];
      pctl_q <= RST_PTR_CTL;
      sts_q <= RST_STATUS;
      ictl_q <= RST_IRQ_CTL;
      imsk_q <= RST_IRQ_MASK;
      rdata_q <= 8'h00;
      res_q <= '0;
      irq_q <= 1'b0;
      pend_q <= '0;
      ist_q <= IS_IDLE;
    end else if (CE_I) begin
      sel_q <= sel_d;
      pctl_q <= pctl_d;
      sts_q <= sts_d;
      ictl_q <= ictl_d;
      imsk_q <= imsk_d;
      rdata_q <= rdata_d;
      res_q <= res_d;
      irq_q <= irq_d;
      pend_q <= pend_d;
      ist_q <= ist_d;
    end
  end

  // clock gating sits outside; this only carries the enable
  logic cg_q;
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      cg_q <= 1'b1;
    end else if (CE_I) begin
      cg_q <= !ictl_d[IC_CGD];
    end
  end

  assign RDATA_O = rdata_q;
  assign ACC_SEL_O = sel_q;
  assign ALU_RES_O = res_q;
  assign IRQ_O = irq_q;
  assign IRQ_PEND_O = pend_q;
  assign CLK_GATE_EN_O = cg_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence clr_write_s;
    CE_I && wr_at(IDX_PTR_CTL) && WDATA_I[PC_ZERO];
  endsequence

  ptr_zero_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    clr_write_s |=> (ACC_SEL_O == 4'h0) && !pctl_q[PC_ZERO])
    else $error("pointer zero strobe failed");
  step_mod2_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && alu_op && pctl_q[2:0] == 3'b001 && !WR_I |=> ACC_SEL_O == {$past(sel_q[3:1]), ~$past(sel_q[0])})
    else $error("modulo 2 step wrong");
  step_off_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && pctl_q[2:0] == 3'b000 && !WR_I |=> $stable(ACC_SEL_O))
    else $error("pointer moved with stepping off");
  step_wins_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && alu_op && st.active && wr_at(IDX_ACC_SEL) && MOVE_ACC_I && !wr_at(IDX_PTR_CTL)
    |=> ACC_SEL_O == $past(st.nxt))
    else $error("moved value beat the step");
  rdonly_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && wr_at(IDX_STATUS) && OP_I == OP_NONE |=> sts_q[SF_OV] == $past(sts_q[SF_OV]))
    else $error("overflow flag was written");
  zero_flag_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && !ACC_WR_I |=> sts_q[SF_Z] == ($past(ACC_I) == '0))
    else $error("zero flag wrong");
  in_service_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && IRQ_ACK_I |=> ictl_q[IC_INS] && !IRQ_O)
    else $error("in-service not set");
  sys_gate_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    IRQ_O |-> ictl_q[IC_GIE] && !ictl_q[IC_INS])
    else $error("interrupt while blocked");
  reserved_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    ##1 (pctl_q[5:3] == 3'b000) && (ictl_q[4:2] == 3'b000) && !sts_q[5])
    else $error("reserved bit set");
endmodule // csr_core_regs

// *** sim/csr_acc_model.sv ***
`timescale 1ns/100ps
module csr_acc_model
  import csr_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic [3:0] sel_i, // active accumulator index
  input wire logic wr_i, // accumulator write
  input wire logic [ACC_W-1:0] new_i, // value written
  output logic [ACC_W-1:0] acc_o // active accumulator
);
  // ****************************************************************
  // accumulator file, all zero at start so the zero flag holds
  // ****************************************************************
  logic [ACC_W-1:0] acc_q [16] = '{default: '0};
  always @(posedge clk_i) begin
    if (wr_i) begin
      acc_q[sel_i] <= new_i;
    end
  end
  assign acc_o = acc_q[sel_i];
endmodule // csr_acc_model

// *** sim/csr_core_regs_bench.sv ***
`timescale 1ns/100ps
module csr_core_regs_bench
  import csr_pkg::*;
();
  logic clk = 1'b0;
  logic nrst;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic mv = 1'b0;
  logic acc_wr = 1'b0;
  logic ack = 1'b0;
  logic ret = 1'b0;
  logic sys_req = 1'b0;
  logic [3:0] widx = 4'h0;
  logic [3:0] ridx = 4'h0;
  logic [7:0] wdata = 8'h00;
  csr_op_t op = OP_NONE;
  logic [15:0] opa = 16'h0000;
  logic [15:0] opb = 16'h0000;
  logic [15:0] acc_new = 16'h0000;
  logic [5:0] mod_req = 6'h00;
  logic [7:0] rdata;
  logic [3:0] sel;
  logic [15:0] res;
  logic [15:0] acc;
  logic irq;
  logic gate;
  logic [6:0] pend;
  int error_cnt = 0;
  int compares = 0;
  always #20 clk = ~clk;
  csr_core_regs csr_core_regs_i (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .WR_I(wr), .WIDX_I(widx),
    .WDATA_I(wdata), .RIDX_I(ridx), .MOVE_ACC_I(mv), .OP_I(op), .OPA_I(opa), .OPB_I(opb), .ACC_I(acc),
    .ACC_WR_I(acc_wr), .ACC_NEW_I(acc_new), .IRQ_ACK_I(ack), .IRQ_RET_I(ret), .MOD_REQ_I(mod_req),
    .SYS_REQ_I(sys_req), .RDATA_O(rdata), .ACC_SEL_O(sel), .ALU_RES_O(res), .IRQ_O(irq),
    .IRQ_PEND_O(pend), .CLK_GATE_EN_O(gate));
  csr_acc_model csr_acc_model_i (.clk_i(clk), .sel_i(sel), .wr_i(acc_wr), .new_i(acc_new), .acc_o(acc));
  // ****************************************************************
  // access tasks; every strobe is followed by an idle edge
  // ****************************************************************
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    repeat (2) cyc();
    nrst = 1'b1;
  endtask
  task automatic wr_reg(input logic [3:0] i, input logic [7:0] d);
    wr = 1'b1;
    widx = i;
    wdata = d;
    cyc();
    wr = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    ridx = i;
    cyc();
    chk($sformatf("reg %0h", i), {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic alu(input csr_op_t o, input logic [15:0] a, input logic [15:0] b);
    op = o;
    opa = a;
    opb = b;
    cyc();
    op = OP_NONE;
    cyc();
  endtask
  task automatic fl(input csr_op_t o, input logic [15:0] a, input logic [15:0] b, input logic [7:0] st,
    input logic [15:0] r);
    alu(o, a, b);
    rd(IDX_STATUS, st);
    chk("result", r, res);
  endtask
  function automatic logic [15:0] exp_step(input int m, input int d);
    logic [3:0] s;
    logic [3:0] k;
    s = d ? 4'h8 : 4'h7;
    k = (m == 0) ? 4'h0 : (m == 1) ? 4'h1 : (m == 2) ? 4'h3 : (m == 3) ? 4'h7 : 4'hf;
    return {12'h000, (s & ~k) | ((d ? s - 4'h1 : s + 4'h1) & k)};
  endfunction
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    do_reset();
    rd(IDX_ACC_SEL, 8'h00);
    rd(IDX_PTR_CTL, 8'h00);
    rd(IDX_STATUS, 8'h80);
    rd(IDX_IRQ_CTL, 8'h00);
    rd(IDX_IRQ_MASK, 8'h00);
    rd(4'h2, 8'h00);
    wr_reg(IDX_ACC_SEL, 8'hff);
    rd(IDX_ACC_SEL, 8'h0f);
    chk("sel", 16'h000f, {12'h000, sel});
    wr_reg(IDX_PTR_CTL, 8'hff);
    rd(IDX_PTR_CTL, 8'h47);
    chk("sel", 16'h0000, {12'h000, sel});
    wr_reg(IDX_STATUS, 8'hff);
    rd(IDX_STATUS, 8'h9b);
    wr_reg(IDX_IRQ_CTL, 8'hff);
    rd(IDX_IRQ_CTL, 8'h23);
    chk("gate", 16'h0000, {15'h0000, gate});
    wr_reg(IDX_IRQ_MASK, 8'hff);
    rd(IDX_IRQ_MASK, 8'hbf);
    // second reset in mid-run must restore irq control, pointer control and gating
    do_reset();
    rd(IDX_IRQ_CTL, 8'h00);
    rd(IDX_PTR_CTL, 8'h00);
    chk("gate", 16'h0001, {15'h0000, gate});
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr_reg(IDX_PTR_CTL, {1'b0, d[0], 3'b000, m[2:0]});
        wr_reg(IDX_ACC_SEL, d ? 8'h08 : 8'h07);
        alu(d ? OP_ADD : OP_LOGIC, 16'h0000, 16'h0000);
        chk("step", exp_step(m, d), {12'h000, sel});
      end
    end
    wr_reg(IDX_PTR_CTL, 8'h04);
    wr_reg(IDX_ACC_SEL, 8'h03);
    // move into pointer coincides with an operation
    mv = 1'b1;
    op = OP_LOGIC;
    wr = 1'b1;
    widx = IDX_ACC_SEL;
    wdata = 8'h09;
    cyc();
    mv = 1'b0;
    op = OP_NONE;
    wr = 1'b0;
    cyc();
    chk("move", 16'h0004, {12'h000, sel});
    // clock enable low: a write and an operation must leave the pointer frozen
    ce = 1'b0;
    wr_reg(IDX_ACC_SEL, 8'h0a);
    alu(OP_LOGIC, 16'h0000, 16'h0000);
    chk("ce hold", 16'h0004, {12'h000, sel});
    ce = 1'b1;
    cyc();
    do_reset();
    fl(OP_ADD, 16'h7fff, 16'h0001, 8'h84, 16'h8000);
    fl(OP_ADD, 16'hffff, 16'h0001, 8'h82, 16'h0000);
    fl(OP_ADD_WITH_CARRY_OP, 16'hffff, 16'h0000, 8'h82, 16'h0000);
    fl(OP_SUBTRACT_WITH_BORROW_OP, 16'h0001, 16'h0001, 8'h82, 16'hffff);
    fl(OP_SUB, 16'h8000, 16'h0001, 8'h84, 16'h7fff);
    fl(OP_SUB, 16'h0000, 16'h0001, 8'h82, 16'hffff);
    fl(OP_ADD, 16'h0001, 16'h0001, 8'h80, 16'h0002);
    alu(OP_CMP, 16'h1234, 16'h1234);
    rd(IDX_STATUS, 8'h81);
    alu(OP_CMP, 16'h1235, 16'h1234);
    rd(IDX_STATUS, 8'h80);
    wr_reg(IDX_STATUS, 8'h00);
    acc_wr = 1'b1;
    acc_new = 16'h8000;
    cyc();
    acc_wr = 1'b0;
    cyc();
    rd(IDX_STATUS, 8'h40);
    wr_reg(IDX_ACC_SEL, 8'h01);
    rd(IDX_STATUS, 8'h80);
    mod_req = 6'h21;
    sys_req = 1'b1;
    wr_reg(IDX_IRQ_MASK, 8'h81);
    chk("pend", 16'h0041, {9'h000, pend});
    chk("irq", 16'h0000, {15'h0000, irq});
    wr_reg(IDX_IRQ_CTL, 8'h01);
    chk("irq", 16'h0001, {15'h0000, irq});
    ack = 1'b1;
    cyc();
    ack = 1'b0;
    rd(IDX_IRQ_CTL, 8'h03);
    chk("irq", 16'h0000, {15'h0000, irq});
    ret = 1'b1;
    cyc();
    ret = 1'b0;
    rd(IDX_IRQ_CTL, 8'h01);
    mod_req = 6'h20;
    wr_reg(IDX_IRQ_MASK, 8'h01);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr_reg(IDX_IRQ_MASK, 8'h80);
    chk("pend", 16'h0040, {9'h000, pend});
    chk("irq", 16'h0001, {15'h0000, irq});
    wr_reg(IDX_IRQ_CTL, 8'h03);
    chk("irq", 16'h0000, {15'h0000, irq});
    wrap_up();
  end
  // run needs about 185 cycles; the margin covers slow settling
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule // csr_core_regs_bench
